// File: hw/lpmc_pkg.sv
// lpmc_pkg: constants, fields and state types of the low-power mode control
// assumes: registers reached over a byte-wide supervisor register port
package lpmc_pkg;

    // =========================================================
    // register offsets
    localparam logic [23:0] LPMC_WAKE_CTRL_OFS = 24'h000012; // wakeup control
    localparam logic [23:0] LPMC_MODE_CFG_OFS  = 24'h110007; // mode config

    // =========================================================
    // field positions
    localparam int LPMC_STOP_EN_BIT   = 7;  // stop_entry_enable
    localparam int LPMC_THR_MSB       = 6;  // wake_level_threshold msb
    localparam int LPMC_THR_LSB       = 4;  // wake_level_threshold lsb
    localparam int LPMC_MODE_MSB      = 7;  // sleep_mode_select msb
    localparam int LPMC_MODE_LSB      = 6;  // sleep_mode_select lsb
    localparam int LPMC_CLKGATE_BIT   = 3;  // clock_output_stop_gate

    // =========================================================
    // reset values
    localparam logic [7:0] LPMC_WAKE_CTRL_RST = 8'h00;
    localparam logic [7:0] LPMC_MODE_CFG_RST  = 8'h00;

    // writable bit masks; all other bits read zero
    localparam logic [7:0] LPMC_WAKE_CTRL_MASK = 8'hf0;
    localparam logic [7:0] LPMC_MODE_CFG_MASK  = 8'hc8;

    // =========================================================
    // mode select codes
    typedef enum logic [1:0] {
        LPMC_SEL_RUN  = 2'b00,
        LPMC_SEL_DOZE = 2'b01,
        LPMC_SEL_WAIT = 2'b10,
        LPMC_SEL_STOP = 2'b11
    } lpmc_sel_type;

    // processor status codes shown while running and while halted
    localparam logic [3:0] LPMC_PSTATE_RUN  = 4'h0;
    localparam logic [3:0] LPMC_PSTATE_HALT = 4'he;

    // controller states
    typedef enum logic [2:0] {
        LPMC_ST_RUN  = 3'b000,
        LPMC_ST_HALT = 3'b001,
        LPMC_ST_DOZE = 3'b010,
        LPMC_ST_WAIT = 3'b011,
        LPMC_ST_STOP = 3'b100
    } lpmc_state_type;

endpackage : lpmc_pkg

// File: hw/lpmc_wake_cmp.sv
// lpmc_wake_cmp: registered wake qualifier from request level and threshold
// assumes: request level comes from logic on clk_sys, 0 means no request
`timescale 1ns/1ns
module lpmc_wake_cmp
    import lpmc_pkg::*;
(
    input  wire logic       clk_sys,   // system clock
    input  wire logic       sys_rst,   // synchronous reset
    input  wire logic [2:0] irq_level, // highest unmasked request level
    input  wire logic [2:0] threshold, // wake_level_threshold field
    input  wire logic       stop_mode, // stop: only fixed sources count
    input  wire logic       irq_fixed, // request comes from a fixed source
    output logic            wake_ff    // registered exit request
);

    // =========================================================
    // level test: request level must exceed the threshold
    // 11x collapses to level 7 only since 6 < level means 7
    function automatic logic lvl_ok(input logic [2:0] lvl,
                                    input logic [2:0] thr);
        logic [2:0] eff;
        eff = (thr[2:1] == 2'b11) ? 3'h6 : thr; // 11x needs level 7
        lvl_ok = (lvl != 3'h0) && (lvl > eff);  // RQ7
    endfunction : lvl_ok

    logic nxt_wake; // combinational qualifier

    // combinational evaluation of unmasked requests
    always_comb begin
        nxt_wake = lvl_ok(irq_level, threshold); // RQ8
        if (stop_mode && !irq_fixed) begin
            nxt_wake = 1'b0; // RQ12
        end
    end

    // exit request register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= nxt_wake; // RQ9
        end
    end

endmodule : lpmc_wake_cmp

// File: hw/lpmc_top.sv
// lpmc_top: low-power mode control with its two supervisor byte registers
// assumes: cpu pulses stop_exec when it issues STOP, register access is a
// one-cycle strobe with offset, supervisor flag and byte data on clk_sys
// outputs are registered from the next state, so clock enables, status
// and lp_state_ff all change on the edge that moves the state
//
// Notes on behaviour
// [RQ1] mode field 11 stop 10 wait 01 doze
// [RQ2] mode 00: halt core, keep clocks running
// [RQ3] mode sampled at STOP; later writes ignored
// [RQ4] mode field always readable and writable
// [RQ5] stop needs stop select and stop enable
// [RQ6] stop enable gates processor clock removal
// [RQ7] threshold: 000 any, else above code
// [RQ8] evaluate requests combinationally against threshold
// [RQ9] qualifying level raises exit request
// [RQ10] exit request re-enables gated clocks
// [RQ11] entry disables clocks of that mode
// [RQ12] stop woken only by fixed sources
// [RQ13] halted core shows dedicated status code
// [RQ14] software programs wakeup control before STOP
// [RQ15] unused bits zero, registers reset zero
// [RQ16] user access errors, leaves registers unchanged
// [RQ17] gate bit stops clock output in stop
// [RQ18] any reset returns to run
// [RQ19] stop without enable only halts core
`timescale 1ns/1ns
module lpmc_top
    import lpmc_pkg::*;
(
    input  wire logic        clk_sys,       // 50 MHz system clock
    input  wire logic        sys_rst,       // synchronous reset, high
    input  wire logic        stop_exec,     // pulse: cpu issued STOP
    input  wire logic [2:0]  irq_level,     // pending unmasked level
    input  wire logic        irq_fixed,     // pending source is fixed
    input  wire logic        reg_sel,       // pulse: register access
    input  wire logic        reg_wr,        // 1 write, 0 read
    input  wire logic        reg_super,     // supervisor mode access
    input  wire logic [23:0] reg_addr,      // offset from base
    input  wire logic [7:0]  reg_wdata,     // write byte
    output logic [7:0]       reg_rdata_ff,  // read byte
    output logic             reg_ack_ff,    // pulse: access done
    output logic             reg_err_ff,    // pulse: transfer error
    output logic             core_halt_ff,  // core held halted
    output logic             core_clk_en_ff,// processor clock enable
    output logic             per_clk_en_ff, // peripheral clock enable
    output logic             clk_out_en_ff, // external_clock_output enable
    output logic             wake_req_ff,   // exit request seen
    output logic [3:0]       processor_state_code_ff, // status code
    output logic [2:0]       lp_state_ff    // current state
);

    // =========================================================
    // registers
    logic [7:0]     low_power_wakeup_control_ff; // wakeup control
    logic [7:0]     low_power_mode_config_ff;    // mode config
    lpmc_state_type state_ff;                    // controller state
    lpmc_state_type nxt_state;                   // next state
    logic           exit_req;                    // from comparator
    logic           hit_wake;                    // wakeup ctrl decode
    logic           hit_mode;                    // mode cfg decode
    logic           in_stop;                     // stop state to comparator

    // field views
    wire logic       stop_entry_enable =
        low_power_wakeup_control_ff[LPMC_STOP_EN_BIT];
    wire logic [2:0] wake_level_threshold =
        low_power_wakeup_control_ff[LPMC_THR_MSB:LPMC_THR_LSB];
    wire logic [1:0] sleep_mode_select =
        low_power_mode_config_ff[LPMC_MODE_MSB:LPMC_MODE_LSB];
    wire logic       clock_output_stop_gate =
        low_power_mode_config_ff[LPMC_CLKGATE_BIT];

    assign hit_wake = (reg_addr == LPMC_WAKE_CTRL_OFS);
    assign hit_mode = (reg_addr == LPMC_MODE_CFG_OFS);

    // =========================================================
    // state decodes shared by several consumers
    // any state other than run holds the core halted
    function automatic logic st_halted(input lpmc_state_type st);
        st_halted = (st != LPMC_ST_RUN);
    endfunction : st_halted

    // core clocks survive only in run and in plain halt
    function automatic logic st_core_clk(input lpmc_state_type st);
        st_core_clk = (st == LPMC_ST_RUN) || (st == LPMC_ST_HALT);
    endfunction : st_core_clk

    // true stop is the only state that removes the peripheral clock
    function automatic logic st_stopped(input lpmc_state_type st);
        st_stopped = (st == LPMC_ST_STOP);
    endfunction : st_stopped

    // comparator must only honour fixed sources while in stop
    assign in_stop = st_stopped(state_ff);

    // =========================================================
    // wake comparator
    lpmc_wake_cmp u_wake (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .irq_level (irq_level),
        .threshold (wake_level_threshold),
        .stop_mode (in_stop),
        .irq_fixed (irq_fixed),
        .wake_ff   (exit_req)
    );

    // =========================================================
    // register writes: supervisor only, unused bits kept zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            low_power_wakeup_control_ff <= LPMC_WAKE_CTRL_RST; // RQ15
            low_power_mode_config_ff    <= LPMC_MODE_CFG_RST;  // RQ15
        end else if (reg_sel && reg_wr && reg_super) begin // RQ16
            if (hit_wake) begin
                // stop enable and wake threshold, low nibble zero
                low_power_wakeup_control_ff <=
                    reg_wdata & LPMC_WAKE_CTRL_MASK; // RQ15
            end
            if (hit_mode) begin
                // writable in every state, never locked
                low_power_mode_config_ff <=
                    reg_wdata & LPMC_MODE_CFG_MASK; // RQ4
            end
        end
    end

    // register answers: ack, read data, error on user access
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_ack_ff   <= 1'b0;
            reg_err_ff   <= 1'b0;
            reg_rdata_ff <= 8'h00;
        end else begin
            // one-cycle answer to every strobe
            reg_ack_ff   <= reg_sel && reg_super;
            reg_err_ff   <= reg_sel && !reg_super; // RQ16
            // data bus idles at zero between reads
            reg_rdata_ff <= 8'h00;
            if (reg_sel && !reg_wr && reg_super) begin
                // supervisor read: mapped offsets only
                if (hit_wake) begin
                    reg_rdata_ff <= low_power_wakeup_control_ff;
                end else if (hit_mode) begin
                    reg_rdata_ff <= low_power_mode_config_ff; // RQ4
                end
            end
        end
    end

    // =========================================================
    // next state: mode sampled only on the STOP pulse
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            LPMC_ST_RUN: begin
                // only run accepts a STOP
                if (stop_exec) begin // RQ3
                    unique case (lpmc_sel_type'(sleep_mode_select)) // RQ1
                        LPMC_SEL_RUN:  nxt_state = LPMC_ST_HALT; // RQ2
                        LPMC_SEL_DOZE: nxt_state = LPMC_ST_DOZE;
                        LPMC_SEL_WAIT: nxt_state = LPMC_ST_WAIT;
                        LPMC_SEL_STOP: begin
                            // stop only with enable set, else plain halt
                            nxt_state = stop_entry_enable ?
                                LPMC_ST_STOP : LPMC_ST_HALT; // RQ5 RQ19
                        end
                    endcase
                end
            end
            LPMC_ST_HALT, LPMC_ST_DOZE, LPMC_ST_WAIT, LPMC_ST_STOP: begin
                // any sleep state leaves on the exit request
                if (exit_req) begin
                    nxt_state = LPMC_ST_RUN; // RQ10
                end
            end
            default: nxt_state = LPMC_ST_RUN; // illegal codes recover
        endcase
    end

    // state register; any reset returns to run
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff <= LPMC_ST_RUN; // RQ18
        end else begin
            // advance to the decoded next state
            state_ff <= nxt_state;
        end
    end

    // =========================================================
    // clock enables and status, decoded from next state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // reset returns every clock and status to run
            core_halt_ff            <= 1'b0;
            core_clk_en_ff          <= 1'b1;
            per_clk_en_ff           <= 1'b1;
            clk_out_en_ff           <= 1'b1;
            wake_req_ff             <= 1'b0;
            processor_state_code_ff <= LPMC_PSTATE_RUN;
            lp_state_ff             <= LPMC_ST_RUN;
        end else begin
            // follow the next state so outputs move with it
            core_halt_ff <= st_halted(nxt_state);
            // core clocks off in doze, wait, stop; kept in halt
            core_clk_en_ff <= st_core_clk(nxt_state); // RQ11 RQ2
            // core and peripheral clocks off in stop, only with enable set
            per_clk_en_ff <= !st_stopped(nxt_state); // RQ6 RQ11
            // clock output follows the gate bit only while stopped
            clk_out_en_ff <= !(st_stopped(nxt_state) &&
                               clock_output_stop_gate); // RQ17
            // exit request shown one cycle after the comparator
            wake_req_ff <= exit_req; // RQ9
            // halted status code for every non-run state
            processor_state_code_ff <= st_halted(nxt_state) ?
                LPMC_PSTATE_HALT : LPMC_PSTATE_RUN; // RQ13
            // state copy for software and checkers
            lp_state_ff <= nxt_state;
        end
    end

endmodule : lpmc_top

// File: verif/lpmc_top_assertions.sv
// lpmc_top_assertions: port checks of the low-power mode controller
// assumes: bound onto lpmc_top, single clock, synchronous reset
`timescale 1ns/1ns
module lpmc_top_assertions
    import lpmc_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       stop_exec,
    input wire logic [2:0] irq_level,
    input wire logic       reg_sel,
    input wire logic       reg_super,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic       reg_ack_ff,
    input wire logic       reg_err_ff,
    input wire logic       core_halt_ff,
    input wire logic       core_clk_en_ff,
    input wire logic       per_clk_en_ff,
    input wire logic       clk_out_en_ff,
    input wire logic       wake_req_ff,
    input wire logic [3:0] processor_state_code_ff,
    input wire logic [2:0] lp_state_ff
);
    // ========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_ACK_SUPER: assert property (reg_sel && reg_super |=>
        reg_ack_ff && !reg_err_ff) else $error("no ack on supervisor access");
    AST_ERR_USER: assert property (reg_sel && !reg_super |=>
        reg_err_ff && !reg_ack_ff && reg_rdata_ff == 8'h00)
        else $error("user access not refused");
    AST_HALT_CLOCKS: assert property (lp_state_ff == 3'h1 |->
        core_clk_en_ff && per_clk_en_ff) else $error("halt gated clocks");
    AST_CORE_GATED: assert property (
        lp_state_ff inside {3'h2, 3'h3} |->
        !core_clk_en_ff && per_clk_en_ff) else $error("doze/wait clocks");
    AST_STOP_CLOCKS: assert property (lp_state_ff == 3'h4 |->
        !core_clk_en_ff && !per_clk_en_ff) else $error("stop clocks");
    AST_STATUS_CODE: assert property (lp_state_ff != 3'h0 |->
        core_halt_ff && processor_state_code_ff == 4'he)
        else $error("halted status code missing");
    AST_ENTER: assert property (stop_exec && lp_state_ff == 3'h0 |=>
        core_halt_ff) else $error("stop not taken");
    AST_WAKE_EXIT: assert property ($rose(wake_req_ff) &&
        $past(lp_state_ff) != 3'h0 |-> lp_state_ff == 3'h0)
        else $error("exit request ignored");
    AST_TOP_LEVEL: assert property (
        lp_state_ff inside {3'h2, 3'h3} && irq_level == 3'h7 |->
        ##[1:3] lp_state_ff == 3'h0)
        else $error("level seven did not wake");
    AST_EXTERNAL_CLOCK_OUTPUT: assert property (lp_state_ff != 3'h4 |->
        clk_out_en_ff) else $error("clock output off outside stop");
    AST_RESET: assert property (disable iff (1'b0) sys_rst |=>
        lp_state_ff == 3'h0 && core_clk_en_ff && !core_halt_ff)
        else $error("reset did not return to run");
    // main scenarios reached
    cover property (lp_state_ff == 3'h4);
    cover property (reg_err_ff);
    cover property ($fell(core_halt_ff));
endmodule : lpmc_top_assertions

bind lpmc_top lpmc_top_assertions i_lpmc_top_assertions (.*);

// File: verif/lpmc_cpu_model.sv
// lpmc_cpu_model: core and interrupt controller seen by the controller
// assumes: bench commands it just after clk_sys edges
`timescale 1ns/1ns
module lpmc_cpu_model (
    input  wire logic       cmd_stop,     // bench wants a STOP issued
    input  wire logic [2:0] cmd_level,    // pending level to present
    input  wire logic       cmd_fixed,    // pending source is fixed
    input  wire logic       core_halt_ff, // core already halted
    output logic            stop_exec,    // STOP issued
    output logic [2:0]      irq_level,    // highest pending level
    output logic            irq_fixed     // fixed source pending
);
    // registers are programmed by the bench before STOP; one per run
    assign stop_exec = cmd_stop & ~core_halt_ff;
    assign irq_level = cmd_level;
    // no request means no fixed source either
    assign irq_fixed = cmd_fixed & (cmd_level != 3'h0);
endmodule : lpmc_cpu_model

// File: verif/testbench.sv
// testbench: self-checking bench of lpmc_top with a cpu model
// assumes: lpmc_pkg compiled, checker bound from its own file
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; \
    if ((got) !== (ex)) begin err_count++; \
    $display("mismatch %s exp %0h got %0h", nm, (ex), (got)); end end
module testbench;
    import lpmc_pkg::*;
    logic        clk_sys, sys_rst, reg_sel, reg_wr, reg_super;
    logic [23:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata_ff;
    logic        cmd_stop, cmd_fixed, stop_exec, irq_fixed;
    logic [2:0]  cmd_level, irq_level, lp_state_ff;
    logic        reg_ack_ff, reg_err_ff, core_halt_ff, core_clk_en_ff;
    logic        per_clk_en_ff, clk_out_en_ff, wake_req_ff;
    logic [3:0]  processor_state_code_ff;
    logic [15:0] lfsr;                      // random source
    int          err_count, checks_done, m_wake, m_mode, lvl;
    lpmc_top       i_lpmc_top (.*);
    lpmc_cpu_model i_lpmc_cpu_model (.*);
    // ========================================================
    // helpers
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_step
    function automatic int exp_state(input int md, input int en);
        return md == 0 ? 1 : md == 1 ? 2 : md == 2 ? 3 : (en ? 4 : 1);
    endfunction : exp_state
    task tick; @(posedge clk_sys); #2; endtask : tick
    task give_verdict;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // one register access, answer checked against the model
    task acc(input logic wr, sup, input logic [23:0] a, input logic [7:0] d);
        int ex;
        tick; reg_sel = 1; reg_wr = wr; reg_super = sup;
        reg_addr = a; reg_wdata = d;
        tick; reg_sel = 0; ex = 0;
        if (sup && wr && a == LPMC_WAKE_CTRL_OFS) m_wake = d & 8'hf0;
        if (sup && wr && a == LPMC_MODE_CFG_OFS) m_mode = d & 8'hc8;
        if (sup && !wr) ex = a == LPMC_WAKE_CTRL_OFS ? m_wake :
                             a == LPMC_MODE_CFG_OFS ? m_mode : 0;
        `CHK("ack", sup, reg_ack_ff)
        `CHK("err", !sup, reg_err_ff)
        `CHK("rdata", ex[7:0], reg_rdata_ff)
    endtask : acc
    // program both registers, issue STOP, check the entered state
    task enter(input int md, en, gate, thr);
        int st;
        acc(1, 1, LPMC_WAKE_CTRL_OFS, {en[0], thr[2:0], 4'h0});
        acc(1, 1, LPMC_MODE_CFG_OFS, {md[1:0], 2'h0, gate[0], 3'h0});
        cmd_stop = 1; tick; cmd_stop = 0; st = exp_state(md, en);
        `CHK("state", st, lp_state_ff)
        `CHK("core_clk", st == 1, core_clk_en_ff)
        `CHK("per_clk", st != 4, per_clk_en_ff)
        `CHK("clk_out", !(st == 4 && gate), clk_out_en_ff)
        `CHK("code", LPMC_PSTATE_HALT, processor_state_code_ff)
    endtask : enter
    // present a request, check wake decision, then force a wake
    task wake(input int lv, fx, thr, st);
        int n, woke;
        cmd_level = 3'(lv);
        cmd_fixed = fx[0];
        n = 0;
        while (lp_state_ff !== 3'h0 && n < 6) begin tick; n++; end
        // 11x behaves as 6: only level 7 is above it
        woke = lv > (thr > 6 ? 6 : thr) && (st != 4 || fx != 0);
        `CHK("woke", woke, lp_state_ff === 3'h0)
        cmd_level = 3'h7;
        cmd_fixed = 1;
        n = 0;
        while (lp_state_ff !== 3'h0 && n < 6) begin tick; n++; end
        `CHK("run", 1, lp_state_ff === 3'h0)
        `CHK("core_run", 1, core_clk_en_ff)
        `CHK("wake_req", 1, wake_req_ff)
        `CHK("code_run", LPMC_PSTATE_RUN, processor_state_code_ff)
        if (lp_state_ff !== 3'h0) give_verdict;
        cmd_level = 0; cmd_fixed = 0; tick; tick;
    endtask : wake
    // ========================================================
    // clock, timeout, main sequence
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        err_count++;
        give_verdict;
    end
    initial begin
        {sys_rst, reg_sel, reg_wr, reg_super, cmd_stop, cmd_fixed} = 6'h20;
        reg_addr = 0; reg_wdata = 0; cmd_level = 0; lfsr = 16'hd95b;
        {err_count, checks_done, m_wake, m_mode} = 0;
        repeat (2) @(posedge clk_sys);
        #2 sys_rst = 0;
        // reset values, masks, unmapped place, user refusal
        acc(0, 1, LPMC_WAKE_CTRL_OFS, 0); acc(0, 1, LPMC_MODE_CFG_OFS, 0);
        acc(1, 1, LPMC_WAKE_CTRL_OFS, 8'hff);
        acc(1, 1, LPMC_MODE_CFG_OFS, 8'hff);
        acc(0, 1, 24'h000013, 0); acc(1, 0, LPMC_MODE_CFG_OFS, 8'h00);
        acc(0, 0, LPMC_WAKE_CTRL_OFS, 0); acc(0, 1, LPMC_MODE_CFG_OFS, 0);
        // every mode, stop with and without enable, writes while asleep
        for (int md = 0; md < 4; md++) for (int en = 0; en < 2; en++) begin
            enter(md, en, 1, 0);
            acc(1, 1, LPMC_MODE_CFG_OFS, 8'h40);
            acc(0, 1, LPMC_MODE_CFG_OFS, 0);
            `CHK("kept", exp_state(md, en), lp_state_ff)
            wake(7, 1, 0, exp_state(md, en));
        end
        // every threshold against a random level
        for (int thr = 0; thr < 8; thr++) begin
            lfsr = lfsr_step(lfsr); lvl = lfsr[2:0];
            enter(2, 0, 0, thr); wake(lvl, 0, thr, 3);
        end
        // stop ignores a programmable source
        enter(3, 1, 0, 0); wake(7, 0, 0, 4);
        // reset in mid stop
        enter(3, 1, 1, 0);
        sys_rst = 1;
        tick;
        sys_rst = 0;
        m_wake = 0;
        m_mode = 0;
        `CHK("rst_state", 3'h0, lp_state_ff)
        `CHK("rst_clk", 1, core_clk_en_ff)
        acc(0, 1, LPMC_MODE_CFG_OFS, 0);
        give_verdict;
    end
endmodule : testbench
